// ### rtl/bdio_glue.sv
// Buffer direction, tristate control and change-of-state interrupt glue
`timescale 1ns/100ps
// Summary of operation
// - Reset: all inputs, tristate feature off
// - Four buffers per group follow port direction
// - New output port clears its latch
// - Control byte with bit7 sets directions
// - Offset A bit per group enables feature
// - Feature on: control bit7 tristates group buffers
// - Buffers stay off until gate bit7 low
// - Gate bit7 high tristates group only
// - Group 1 uses offsets 7, 9 and D
// - Select registers gate each port buffer
// - Select bits 4,3,1,0 map A,CU,B,CL
// - Change interrupts blocked until mask first written
// - Offset B readable mask, one disables
// - Mask bits 0-3 group 0, 4-7 group 1
// - Offset F reads change status
// - Any write to F clears status
// - Read of 18 returns status and clears
// - Interrupt line floats when idle
// - Low pulse 500 ns, edge, release
// - Control bits set A,CU,B,CL direction
module bdio_glue
    import bdio_pkg::*;
#(
    parameter int GROUPS = 2
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [bdio_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [bdio_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [bdio_pkg::DATA_W-1:0] bus_rdata,
    output logic bus_rdata_oe,
    input wire logic [GROUPS*24-1:0] line_in,
    output logic [GROUPS*4-1:0] buffer_dir_out,
    output logic [GROUPS*4-1:0] buffer_enable,
    output logic [GROUPS*4-1:0] port_latch_clear,
    output logic irq_out,
    output logic irq_oe
);
    import bdio_pkg::*;

    // =====================================================
    // Decode helpers
    // Pull the four section bits (A, B, CL, CU order) out of a control-style byte
    function automatic logic [3:0] bdio_sections(input logic [7:0] b);
        bdio_sections = {b[CTL_PORT_C_UPPER], b[CTL_PORT_C_LOWER], b[CTL_PORT_B], b[CTL_PORT_A]};
    endfunction

    // Eight input lines of a section; the nibble sections zero-extend
    function automatic logic [7:0] bdio_section_bits(input logic [23:0] lines, input int sec);
        logic [7:0] r;
        r = RST_ZERO;
        case (sec)
            SEC_A: r = lines[7:0];
            SEC_B: r = lines[15:8];
            SEC_CL: r = {4'h0, lines[19:16]};
            SEC_CU: r = {4'h0, lines[23:20]};
            default: r = RST_ZERO;
        endcase
        bdio_section_bits = r;
    endfunction

    // Strobe for one offset; every bus side effect is decoded through here
    function automatic logic bdio_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] ofs);
        bdio_hit = strobe && (addr == ofs);
    endfunction

    logic [7:0] tristate_feature_enable;
    logic [7:0] change_irq_mask;
    logic [7:0] change_status;
    logic [7:0] group_select [GROUPS];
    logic [3:0] port_is_input [GROUPS];
    logic group_gate_off [GROUPS];
    logic [7:0] section_prev [GROUPS*SECTIONS];
    logic [GROUPS*SECTIONS-1:0] change_seen;
    logic status_clear;
    logic irq_fire;
    logic irq_pending;
    logic sampled_valid;
    logic wr_feature;
    logic wr_mask;
    logic wr_status;
    logic rd_status;
    logic irq_latch;

    // =====================================================
    // Per-group control: directions, gate and select
    // Group 1 differs from group 0 only in its three offsets
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : grp
            localparam logic [4:0] CTRL_OFS = (g == 0) ? OFS_GROUP0_CTRL : OFS_GROUP1_CTRL;
            localparam logic [4:0] GATE_OFS = (g == 0) ? OFS_GROUP0_BUFFER_GATE : OFS_GROUP1_BUFFER_GATE;
            localparam logic [4:0] SEL_OFS = (g == 0) ? OFS_GROUP0_PORT_BUFFER_SELECT
                                                      : OFS_GROUP1_PORT_BUFFER_SELECT;
            logic ctrl_set;
            logic [3:0] next_input;
            assign ctrl_set = bdio_hit(bus_wr, bus_addr, CTRL_OFS) && bus_wdata[CTL_MODE_SET];
            assign next_input = bdio_sections(bus_wdata);

            // Mode-set writes steer direction; a port turning to output clears its latch
            // Every mode-set clears all its output ports, as the port chip itself does
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    port_is_input[g] <= RST_DIR_INPUT;
                    port_latch_clear[g*4 +: 4] <= 4'h0;
                end else if (ctrl_set) begin
                    port_is_input[g] <= next_input;
                    port_latch_clear[g*4 +: 4] <= ~next_input;
                end else begin
                    port_latch_clear[g*4 +: 4] <= 4'h0;
                end
            end

            // Group gate: set by mode-set bit7, released only by a gate write with bit7 low
            // It latches with the feature off too; it only matters once the feature is on
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    group_gate_off[g] <= 1'b0;
                end else if (ctrl_set) begin
                    group_gate_off[g] <= 1'b1;
                end else if (bdio_hit(bus_wr, bus_addr, GATE_OFS)) begin
                    group_gate_off[g] <= bus_wdata[CTL_MODE_SET];
                end
            end

            // Selective enables; reset opens every port so the feature stays inert
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    group_select[g] <= RST_SELECT;
                end else if (bdio_hit(bus_wr, bus_addr, SEL_OFS)) begin
                    group_select[g] <= bus_wdata;
                end
            end

            // Buffer outputs; each section's select bit ands with the group gate
            // Registered once more, so the buffers lag a control write by two edges
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    buffer_dir_out[g*4 +: 4] <= 4'h0;
                    buffer_enable[g*4 +: 4] <= 4'hF;
                end else begin
                    buffer_dir_out[g*4 +: 4] <= ~port_is_input[g];
                    if (!tristate_feature_enable[g]) begin
                        buffer_enable[g*4 +: 4] <= 4'hF;
                    end else begin
                        buffer_enable[g*4 +: 4] <= {4{~group_gate_off[g]}}
                                                   & bdio_sections(group_select[g]);
                    end
                end
            end
        end
    endgenerate

    // =====================================================
    // Shared registers
    // Decoded strobes; the status mirror read clears, so it is decoded like a write
    assign wr_feature = bdio_hit(bus_wr, bus_addr, OFS_TRISTATE_FEATURE_ENABLE);
    assign wr_mask = bdio_hit(bus_wr, bus_addr, OFS_CHANGE_IRQ_MASK);
    assign wr_status = bdio_hit(bus_wr, bus_addr, OFS_CHANGE_STATUS_WRITE_CLEAR);
    assign rd_status = bdio_hit(bus_rd, bus_addr, OFS_CHANGE_STATUS_READ_CLEAR);

    // Feature register keeps one bit per group; the upper bits read as zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tristate_feature_enable <= RST_ZERO;
        end else if (wr_feature) begin
            tristate_feature_enable <= DATA_W'(bus_wdata[GROUPS-1:0]);
        end
    end

    // Mask: a one disables a section; reset value zero enables all, quiet only until first written
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            change_irq_mask <= RST_ZERO;
        end else if (wr_mask) begin
            change_irq_mask <= bus_wdata;
        end
    end

    // =====================================================
    // Change detection
    // Until the mask is first written, nothing may interrupt even though mask reads zero
    logic mask_programmed;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mask_programmed <= 1'b0;
        end else if (wr_mask) begin
            mask_programmed <= 1'b1;
        end
    end

    // Nibble sections compare only their four lines; the upper bits stay zero
    genvar s;
    generate
        for (s = 0; s < GROUPS*SECTIONS; s++) begin : sec
            logic [7:0] now_bits;
            assign now_bits = bdio_section_bits(line_in[(s/SECTIONS)*24 +: 24], s % SECTIONS);
            // Previous sample, compared every clock
            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    section_prev[s] <= RST_ZERO;
                end else begin
                    section_prev[s] <= now_bits;
                end
            end
            assign change_seen[s] = sampled_valid && mask_programmed && !change_irq_mask[s]
                                    && port_is_input[s/SECTIONS][s % SECTIONS]
                                    && (now_bits != section_prev[s]);
        end
    endgenerate

    // First cycle after reset has no valid previous sample,
    // so a line that idles high cannot pass for a change at start-up
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sampled_valid <= 1'b0;
        end else begin
            sampled_valid <= 1'b1;
        end
    end

    assign status_clear = wr_status || rd_status;

    // Sticky status; a change in the clearing cycle survives the clear
    // Limitation: repeated changes of one section before service show as one bit
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            change_status <= RST_ZERO;
        end else if (status_clear) begin
            change_status <= 8'(change_seen);
        end else begin
            change_status <= change_status | 8'(change_seen);
        end
    end

    // A new latch: a change while idle, or one that lands in a clearing cycle
    assign irq_latch = |change_seen && (!irq_pending || status_clear);

    // Latched request: one line pulse per latch, rearmed by a clear; set wins
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_pending <= 1'b0;
        end else if (irq_latch) begin
            irq_pending <= 1'b1;
        end else if (status_clear) begin
            irq_pending <= 1'b0;
        end
    end

    // Fire request; held while the line driver is busy, since a rearm during a
    // pulse would otherwise be dropped and the host would never see it
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_fire <= 1'b0;
        end else if (irq_latch) begin
            irq_fire <= 1'b1;
        end else begin
            irq_fire <= irq_fire && irq_oe;
        end
    end

    // Line driver shapes the shareable interrupt pulse
    bdio_irq_pulse u_irq (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .fire(irq_fire),
        .irq_out(irq_out),
        .irq_oe(irq_oe)
    );

    // =====================================================
    // Read path, registered; unmapped offsets float the data bus
    // The select registers read back all eight bits, the ignored ones included
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bus_rdata <= RST_ZERO;
            bus_rdata_oe <= 1'b0;
        end else begin
            bus_rdata <= RST_ZERO;
            bus_rdata_oe <= bus_rd;
            if (bus_rd) begin
                case (bus_addr)
                    OFS_TRISTATE_FEATURE_ENABLE: bus_rdata <= tristate_feature_enable;
                    OFS_CHANGE_IRQ_MASK: bus_rdata <= change_irq_mask;
                    OFS_GROUP0_PORT_BUFFER_SELECT: bus_rdata <= group_select[0];
                    OFS_GROUP1_PORT_BUFFER_SELECT: bus_rdata <= group_select[GROUPS-1];
                    OFS_CHANGE_STATUS_WRITE_CLEAR: bus_rdata <= change_status;
                    OFS_CHANGE_STATUS_READ_CLEAR: bus_rdata <= change_status;
                    default: bus_rdata_oe <= 1'b0;
                endcase
            end
        end
    end
endmodule

// ### rtl/bdio_pkg.sv
// Package: register offsets, control-byte fields and timing constants for the buffered DIO glue
package bdio_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    // Register offsets within the 32-byte window
    localparam logic [4:0] OFS_GROUP0_CTRL = 5'h03;
    localparam logic [4:0] OFS_GROUP1_CTRL = 5'h07;
    localparam logic [4:0] OFS_GROUP0_BUFFER_GATE = 5'h08;
    localparam logic [4:0] OFS_GROUP1_BUFFER_GATE = 5'h09;
    localparam logic [4:0] OFS_TRISTATE_FEATURE_ENABLE = 5'h0A;
    localparam logic [4:0] OFS_CHANGE_IRQ_MASK = 5'h0B;
    localparam logic [4:0] OFS_GROUP0_PORT_BUFFER_SELECT = 5'h0C;
    localparam logic [4:0] OFS_GROUP1_PORT_BUFFER_SELECT = 5'h0D;
    localparam logic [4:0] OFS_CHANGE_STATUS_WRITE_CLEAR = 5'h0F;
    localparam logic [4:0] OFS_CHANGE_STATUS_READ_CLEAR = 5'h18;
    // Control byte fields (also used by the select registers)
    localparam int CTL_MODE_SET = 7;
    localparam int CTL_PORT_A = 4;
    localparam int CTL_PORT_C_UPPER = 3;
    localparam int CTL_PORT_B = 1;
    localparam int CTL_PORT_C_LOWER = 0;
    // Section index within a group (mask/status order)
    localparam int SEC_A = 0;
    localparam int SEC_B = 1;
    localparam int SEC_CL = 2;
    localparam int SEC_CU = 3;
    localparam int SECTIONS = 4;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SELECT = 8'hFF;
    localparam logic [3:0] RST_DIR_INPUT = 4'hF;
    // Interrupt pulse timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int IRQ_LOW_MIN_NS = 500;
    localparam int IRQ_LOW_CYCLES = (IRQ_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_CNT_W = $clog2(IRQ_LOW_CYCLES + 1);
endpackage

// ### rtl/bdio_irq_pulse.sv
// Shareable interrupt line driver: low pulse, rising edge, then release
`timescale 1ns/100ps
module bdio_irq_pulse
    import bdio_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic fire,
    output logic irq_out,
    output logic irq_oe
);
    typedef enum logic [1:0] {BDIO_IDLE, BDIO_LOW, BDIO_HIGH} bdio_irq_state_t;
    bdio_irq_state_t state;
    logic [IRQ_CNT_W-1:0] count;

    // =====================================================
    // Pulse sequencer
    // Line floats except during the pulse so other boards may share it
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= BDIO_IDLE;
            count <= '0;
            irq_out <= 1'b1;
            irq_oe <= 1'b0;
        end else begin
            case (state)
                BDIO_IDLE: begin
                    if (fire) begin
                        state <= BDIO_LOW;
                        count <= '0;
                        irq_out <= 1'b0;
                        irq_oe <= 1'b1;
                    end
                end
                BDIO_LOW: begin
                    if (count == IRQ_CNT_W'(IRQ_LOW_CYCLES - 1)) begin
                        state <= BDIO_HIGH;
                        irq_out <= 1'b1;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                BDIO_HIGH: begin
                    state <= BDIO_IDLE; // One driven-high cycle gives the rising edge
                    irq_oe <= 1'b0;
                end
                default: begin
                    state <= BDIO_IDLE;
                    irq_oe <= 1'b0;
                    irq_out <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ### dv/bdio_glue_sva.sv
// Checker: port-level properties of the buffered DIO glue
`timescale 1ns/100ps
module bdio_glue_sva
    import bdio_pkg::*;
#(
    parameter int GROUPS = 2
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [bdio_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [bdio_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [bdio_pkg::DATA_W-1:0] bus_rdata,
    input wire logic bus_rdata_oe,
    input wire logic [GROUPS*24-1:0] line_in,
    input wire logic [GROUPS*4-1:0] buffer_dir_out,
    input wire logic [GROUPS*4-1:0] buffer_enable,
    input wire logic [GROUPS*4-1:0] port_latch_clear,
    input wire logic irq_out,
    input wire logic irq_oe
);
    // ==========
    // Shadow state
    logic [7:0] wd1, wd2, mask_q;
    logic [2:0] f0;
    logic feat0;
    logic mask_w;
    // Feature bit history spans the two-edge buffer lag
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            feat0 <= 1'b0;
            f0 <= 3'h0;
            mask_q <= 8'h00;
            mask_w <= 1'b0;
        end else begin
            if (bus_wr && bus_addr == OFS_TRISTATE_FEATURE_ENABLE) begin
                feat0 <= bus_wdata[0];
            end
            if (bus_wr && bus_addr == OFS_CHANGE_IRQ_MASK) begin
                mask_q <= bus_wdata;
                mask_w <= 1'b1;
            end
            f0 <= {f0[1:0], feat0};
        end
    end
    // Write data delayed to line up with the direction outputs
    always_ff @(posedge ref_clk) begin
        wd1 <= bus_wdata;
        wd2 <= wd1;
    end
    // ==========
    // Properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_reset_state: assert property ($rose(rst_b) |-> buffer_dir_out == '0 && &buffer_enable && !irq_oe)
        else $error("outputs not at reset values");
    a_group0_dir: assert property (
        bus_wr && bus_addr == OFS_GROUP0_CTRL && bus_wdata[7]
        |-> ##2 buffer_dir_out[3:0] == ~{wd2[3], wd2[0], wd2[1], wd2[4]})
        else $error("group 0 direction wrong");
    a_group1_dir: assert property (
        bus_wr && bus_addr == OFS_GROUP1_CTRL && bus_wdata[7]
        |-> ##2 buffer_dir_out[7:4] == ~{wd2[3], wd2[0], wd2[1], wd2[4]})
        else $error("group 1 direction wrong");
    a_pulse_shape: assert property (
        $rose(irq_oe) |-> (irq_oe && !irq_out) [*5] ##1 (irq_oe && !irq_out) [*5]
        ##1 (irq_oe && irq_out) ##1 !irq_oe)
        else $error("interrupt pulse shape wrong");
    a_mask_gate: assert property (!mask_w |-> !irq_oe)
        else $error("interrupt before mask written");
    a_unmapped_read: assert property (bus_rd && (bus_addr == 5'h0E || bus_addr > 5'h18) |=> !bus_rdata_oe)
        else $error("unmapped read answered");
    a_mask_read: assert property (
        bus_rd && bus_addr == OFS_CHANGE_IRQ_MASK |=> bus_rdata_oe && bus_rdata == mask_q)
        else $error("mask readback wrong");
    a_status_read: assert property (bus_rd && bus_addr == OFS_CHANGE_STATUS_READ_CLEAR |=> bus_rdata_oe)
        else $error("status read not answered");
    a_clear_pulse: assert property (|port_latch_clear |=> (port_latch_clear & $past(port_latch_clear)) == '0)
        else $error("latch clear longer than one cycle");
    a_feature_off: assert property (f0 == 3'h0 && !feat0 |-> &buffer_enable[3:0])
        else $error("group 0 tristated with feature off");
endmodule
bind bdio_glue bdio_glue_sva #(.GROUPS(GROUPS)) u_sva (.ref_clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .bus_rdata_oe, .line_in, .buffer_dir_out, .buffer_enable, .port_latch_clear, .irq_out, .irq_oe);

// ### dv/bdio_host.sv
// Host model: register cycles and a pulled-up, edge-counted interrupt line
`timescale 1ns/100ps
module bdio_host
    import bdio_pkg::*;
(
    input wire logic ref_clk,
    output logic [bdio_pkg::ADDR_W-1:0] bus_addr,
    output logic [bdio_pkg::DATA_W-1:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input wire logic [bdio_pkg::DATA_W-1:0] bus_rdata,
    input wire logic bus_rdata_oe,
    input wire logic irq_out,
    input wire logic irq_oe
);
    wire irq_line;
    int irq_edges = 0;
    int low_len = 0;
    int last_low = 0;
    initial begin
        bus_addr = 5'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end
    // Pull-up holds the shared line high while nobody drives it
    assign irq_line = irq_oe ? irq_out : 1'b1;
    // Controller counts rising edges and measures the low time
    always @(posedge ref_clk) begin
        if (irq_line === 1'b0) begin
            low_len <= low_len + 1;
        end else begin
            if (low_len != 0) begin
                irq_edges <= irq_edges + 1;
                last_low <= low_len;
            end
            low_len <= 0;
        end
    end
    // Released lines show the inverse so stale data never looks valid
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        bus_wr = 1'b0;
        bus_addr = ~a;
        bus_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic oe);
        @(posedge ref_clk);
        #1;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        bus_rd = 1'b0;
        bus_addr = ~a;
        d = bus_rdata;
        oe = bus_rdata_oe;
    endtask
endmodule

// ### dv/tb_top.sv
// Testbench: directed scenarios for the buffered DIO glue
`timescale 1ns/100ps
module tb_top;
    import bdio_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [47:0] line_in = 48'h0;
    logic [4:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, buffer_dir_out, buffer_enable, port_latch_clear, clr_seen, rd_d;
    logic bus_wr, bus_rd, bus_rdata_oe, irq_out, irq_oe, rd_oe;
    int err_total = 0;
    int comparisons = 0;
    int edges;
    always #25 ref_clk = ~ref_clk;
    // Collect latch-clear pulses, which stand for one cycle only
    always @(posedge ref_clk) clr_seen <= rst_b ? (clr_seen | port_latch_clear) : 8'h00;
    bdio_host host (.ref_clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .bus_rdata_oe, .irq_out, .irq_oe);
    bdio_glue #(.GROUPS(2)) dut (.ref_clk, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .bus_rdata_oe, .line_in, .buffer_dir_out, .buffer_enable, .port_latch_clear, .irq_out, .irq_oe);
    // ==========
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        host.rd(a, rd_d, rd_oe);
        chk({7'h00, rd_oe}, 8'h01);
        chk(rd_d, exp);
    endtask
    // Buffers lag a write by two edges; three leaves margin
    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic stop_test;
        $display("err_total %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        chk(buffer_dir_out, 8'h00);
        chk(buffer_enable, 8'hFF);
        rchk(OFS_CHANGE_IRQ_MASK, 8'h00);
        rchk(OFS_TRISTATE_FEATURE_ENABLE, 8'h00);
        host.rd(5'h0E, rd_d, rd_oe);
        chk({7'h00, rd_oe}, 8'h00);
    endtask
    task automatic t_direction;
        host.wr(OFS_GROUP0_CTRL, 8'h98);
        host.wr(OFS_GROUP1_CTRL, 8'h80);
        settle();
        chk(buffer_dir_out, 8'hF6);
        chk(clr_seen, 8'hF6);
        chk(buffer_enable, 8'hFF);
        host.wr(OFS_GROUP0_CTRL, 8'h1B);
        settle();
        chk(buffer_dir_out, 8'hF6);
    endtask
    task automatic t_tristate;
        host.wr(OFS_TRISTATE_FEATURE_ENABLE, 8'hFF);
        rchk(OFS_TRISTATE_FEATURE_ENABLE, 8'h03);
        host.wr(OFS_GROUP0_CTRL, 8'h89);
        settle();
        chk(buffer_enable, 8'h00);
        chk(buffer_dir_out, 8'hF3);
        // Both gates open first, then a group 0 control write without bit7 keeps them open
        host.wr(OFS_GROUP0_BUFFER_GATE, 8'h09);
        host.wr(OFS_GROUP1_BUFFER_GATE, 8'h00);
        host.wr(OFS_GROUP0_CTRL, 8'h09);
        settle();
        chk(buffer_enable, 8'hFF);
        host.wr(OFS_GROUP1_BUFFER_GATE, 8'h80);
        settle();
        chk(buffer_enable, 8'h0F);
        chk(buffer_dir_out, 8'hF3);
        host.wr(OFS_GROUP1_BUFFER_GATE, 8'h00);
    endtask
    task automatic t_select;
        host.wr(OFS_GROUP0_PORT_BUFFER_SELECT, 8'hF2);
        host.wr(OFS_GROUP1_PORT_BUFFER_SELECT, 8'h2D);
        rchk(OFS_GROUP0_PORT_BUFFER_SELECT, 8'hF2);
        settle();
        chk(buffer_enable, 8'hC3);
        host.wr(OFS_GROUP0_PORT_BUFFER_SELECT, 8'hFF);
        host.wr(OFS_GROUP1_PORT_BUFFER_SELECT, 8'hFF);
        host.wr(OFS_GROUP0_BUFFER_GATE, 8'h80);
        host.wr(OFS_TRISTATE_FEATURE_ENABLE, 8'h00);
        settle();
        chk(buffer_enable, 8'hFF);
    endtask
    task automatic t_change;
        host.wr(OFS_GROUP1_CTRL, 8'h9B);
        edges = host.irq_edges;
        line_in[28] = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1;
        chk(8'(host.irq_edges - edges), 8'h00);
        host.wr(OFS_CHANGE_IRQ_MASK, 8'hEF);
        rchk(OFS_CHANGE_IRQ_MASK, 8'hEF);
        line_in[33:32] = 2'h3;
        settle();
        line_in[24] = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1;
        chk(8'(host.irq_edges - edges), 8'h01);
        chk({7'h00, host.last_low >= IRQ_LOW_CYCLES}, 8'h01);
        rchk(OFS_CHANGE_STATUS_WRITE_CLEAR, 8'h10);
        rchk(OFS_CHANGE_STATUS_READ_CLEAR, 8'h10);
        rchk(OFS_CHANGE_STATUS_WRITE_CLEAR, 8'h00);
        line_in[27] = 1'b1;
        repeat (16) @(posedge ref_clk);
        #1;
        chk(8'(host.irq_edges - edges), 8'h02);
        host.wr(OFS_CHANGE_STATUS_WRITE_CLEAR, 8'h5A);
        rchk(OFS_CHANGE_STATUS_WRITE_CLEAR, 8'h00);
        // A rearm that lands while the first pulse still runs gets a pulse of its own
        line_in[26] = 1'b1;
        host.rd(OFS_CHANGE_STATUS_READ_CLEAR, rd_d, rd_oe);
        line_in[25] = 1'b1;
        repeat (32) @(posedge ref_clk);
        #1;
        chk(8'(host.irq_edges - edges), 8'h04);
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_direction();
        t_tristate();
        t_select();
        t_change();
        stop_test();
    end
    // Watchdog: the run needs about 185 cycles
    initial begin
        #200000;
        err_total++;
        stop_test();
    end
endmodule
